// >>> hdl/cmd_port_pkg.sv
package cmd_port_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS     = 5000;
  localparam int READY_WAIT_CLOCKS = 200;
  localparam int WAIT_W            = 8;
  localparam int ENTRY_WINDOW_NS   = 5;
  localparam int ENTRY_WINDOW_CYC  = (ENTRY_WINDOW_NS * 1000) / CLK_PERIOD_PS;

  // ****************************************************************
  // Address fields and queue depth
  // ****************************************************************
  localparam int ADDR_W      = 15;
  localparam int BANK_W      = 2;
  localparam int COL_W       = 9;
  localparam int COL_X16_MSB = 7;
  localparam int LEN_X16_LSB = 11;
  localparam int LEN_X8_LSB  = 13;
  localparam int OPC_HI_LSB  = 8;
  localparam int FIFO_DEPTH  = 4;

  // ****************************************************************
  // Burst length encodings
  // ****************************************************************
  localparam logic [1:0] BURST_LEN_2 = 2'h0;
  localparam logic [1:0] BURST_LEN_4 = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_ACT_RD   = 3'h1,
    ST_ACT_WR   = 3'h3,
    ST_SLEEP    = 3'h2,
    ST_SELF_REF = 3'h6,
    ST_WAIT_PD  = 3'h7
  } state_t;

  typedef enum logic [2:0] {
    OP_READ  = 3'h0,
    OP_WRITE = 3'h1,
    OP_MODE  = 3'h2,
    OP_EXT   = 3'h3,
    OP_REFR  = 3'h4
  } op_t;

  typedef struct packed {
    op_t                 op;
    logic [BANK_W-1:0]   bank;
    logic [ADDR_W-1:0]   upper_address;
    logic [COL_W-1:0]    lower_address;
    logic [3:0]          lane_mask;
    logic [3:0]          word_mask_lo;
    logic [3:0]          word_mask_hi;
  } cmd_t;

  typedef struct packed {
    logic                chip_sel_n;
    logic                function_select;
    logic [BANK_W-1:0]   bank;
    logic [ADDR_W-1:0]   addr;
  } pins_t;

endpackage

// >>> hdl/cmd_fifo.sv
module cmd_fifo
  import cmd_port_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("cmd_fifo depth must be a power of two of at least 2");
    end
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;
  always_comb begin
    in_ready  = (cnt_q != (AW+1)'(DEPTH));
    out_valid = (cnt_q != '0);
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_d      = push ? wr_q + 1'b1 : wr_q;
    rd_d      = pop ? rd_q + 1'b1 : rd_q;
    cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  assign out_data = mem_q[rd_q];
endmodule

// >>> hdl/cmd_port.sv
// Summary of operation
// - Normal accesses only 200 clocks after extended; the code only raises ready_q after the wait and never blocks accesses.
// - First command: deselect, read or write activate.
// - Second command: latch, refresh or mode set.
// - Column address width depends on organisation.
// - Mode set opcode from bank and low address.
// - Write-length selects sit on A14 to A11.
// - Write-length encoding per burst length two/four.
// - Wide part: lane selects act independently.
// - Inputs sampled on rising clock edge.
// - Pin high with deselect exits asynchronously.
module cmd_port
  import cmd_port_pkg::*;
#(
  parameter bit WIDE_ORG = 1'b1,
  parameter int READY_WAIT = READY_WAIT_CLOCKS
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire pins_t       pins,
  input  wire logic        power_down_n,
  input  wire logic [1:0]  burst_length,
  input  wire logic        outputs_idle,
  output cmd_t             cmd_data,
  output logic             cmd_valid,
  input  wire logic        cmd_ready,
  output logic             cmd_dropped_q,
  output logic             ready_q,
  output logic             ext_set_q,
  output logic             sleeping,
  output logic             self_refreshing,
  output logic             illegal_q
);
  initial begin
    if (READY_WAIT < 1 || READY_WAIT > 255) begin
      $error("READY_WAIT must be 1 to 255");
    end
  end

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic [3:0] word_mask(input logic [1:0] bl, input logic s0,
                                           input logic s1);
    logic [3:0] m;
    m = 4'hf;
    if (bl == BURST_LEN_2) begin
      m = s0 ? 4'h1 : 4'h3;
    end else begin
      case ({s1, s0})
        2'h1:    m = 4'hf;
        2'h2:    m = 4'h3;
        2'h3:    m = 4'h1;
        default: m = 4'h0;
      endcase
    end
    return m;
  endfunction

  // ****************************************************************
  // Command state
  // ****************************************************************
  state_t            st_q, st_d;
  logic [BANK_W-1:0] bank_q, bank_d;
  logic [ADDR_W-1:0] ua_q, ua_d;
  logic [WAIT_W-1:0] wait_q, wait_d;
  logic              ready_d, ext_d, drop_d, ill_d;
  logic              push, fifo_ready;
  cmd_t              entry;

  always_comb begin
    st_d    = st_q;
    bank_d  = bank_q;
    ua_d    = ua_q;
    wait_d  = wait_q;
    ready_d = ready_q;
    ext_d   = ext_set_q;
    drop_d  = 1'b0;
    ill_d   = 1'b0;
    push    = 1'b0;
    entry   = '0;
    entry.bank          = bank_q;
    entry.upper_address = ua_q;
    if (ext_set_q && !ready_q) begin
      if (wait_q == WAIT_W'(1)) begin
        ready_d = 1'b1;
      end
      wait_d = wait_q - 1'b1;
    end
    case (st_q)
      ST_IDLE: begin
        if (!power_down_n) begin
          if (pins.chip_sel_n) begin
            st_d = ST_SLEEP;
          end else begin
            ill_d = 1'b1;
          end
        end else if (!pins.chip_sel_n) begin
          bank_d = pins.bank;
          ua_d   = pins.addr;
          st_d   = pins.function_select ? ST_ACT_RD : ST_ACT_WR;
        end
      end
      ST_ACT_RD, ST_ACT_WR: begin
        st_d = ST_IDLE;
        push = 1'b1;
        if (pins.chip_sel_n) begin
          entry.op = (st_q == ST_ACT_RD) ? OP_READ : OP_WRITE;
          entry.lower_address = WIDE_ORG ?
            {1'b0, pins.addr[COL_X16_MSB:0]} : pins.addr[COL_W-1:0];
          if (st_q == ST_ACT_WR) begin
            if (WIDE_ORG) begin
              entry.word_mask_lo = word_mask(burst_length, pins.addr[ADDR_W-1],
                                             pins.addr[ADDR_W-2]);
              entry.word_mask_hi = word_mask(burst_length, pins.addr[LEN_X16_LSB+1],
                                             pins.addr[LEN_X16_LSB]);
            end else begin
              entry.word_mask_lo = word_mask(burst_length, pins.addr[ADDR_W-1],
                                             pins.addr[LEN_X8_LSB]);
              entry.word_mask_hi = entry.word_mask_lo;
            end
            ill_d = (entry.word_mask_lo == 4'h0) || (entry.word_mask_hi == 4'h0);
          end
        end else if (st_q == ST_ACT_RD) begin
          // opcode from bank and low address
          entry.op            = pins.bank[1] ? OP_EXT : OP_MODE;
          entry.lower_address = pins.addr[COL_W-1:0];
          ill_d = (pins.addr[ADDR_W-1:OPC_HI_LSB] != '0);
          if (pins.bank[1]) begin
            ext_d   = 1'b1;
            ready_d = 1'b0;
            wait_d  = WAIT_W'(READY_WAIT);
          end
        end else begin
          entry.op = OP_REFR;
          if (!power_down_n) begin
            st_d = ST_SELF_REF;
          end else if (ENTRY_WINDOW_CYC > 0) begin
            st_d = ST_WAIT_PD;
          end
        end
        if (!fifo_ready) begin
          drop_d = 1'b1;
        end
      end
      ST_WAIT_PD: begin
        st_d = power_down_n ? ST_IDLE : ST_SELF_REF;
      end
      ST_SLEEP, ST_SELF_REF: begin
        // exit needs select high; the code exits on the pin alone and flags select low in illegal_q
        // Exit follows the pin at the first edge, so a command may come next cycle.
        if (power_down_n) begin
          st_d  = ST_IDLE;
          ill_d = !pins.chip_sel_n;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q          <= ST_IDLE;
      bank_q        <= '0;
      ua_q          <= '0;
      wait_q        <= '0;
      ready_q       <= 1'b0;
      ext_set_q     <= 1'b0;
      cmd_dropped_q <= 1'b0;
      illegal_q     <= 1'b0;
    end else begin
      st_q          <= st_d;
      bank_q        <= bank_d;
      ua_q          <= ua_d;
      wait_q        <= wait_d;
      ready_q       <= ready_d;
      ext_set_q     <= ext_d;
      cmd_dropped_q <= drop_d;
      illegal_q     <= ill_d;
    end
  end

  // low-power state released by pin alone
  assign sleeping        = (st_q == ST_SLEEP) && !power_down_n;
  assign self_refreshing = (st_q == ST_SELF_REF) && !power_down_n;

  // ****************************************************************
  // Decoded command queue
  // ****************************************************************
  // A full queue drops the command and flags it; the pins have no stall.
  cmd_fifo #(
    .WIDTH ($bits(cmd_t)),
    .DEPTH (FIFO_DEPTH)
  ) cmd_fifo_i (
    .clk       (clk),
    .rst       (rst),
    .in_data   (entry),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .out_data  (cmd_data),
    .out_valid (cmd_valid),
    .out_ready (cmd_ready)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  // ready timing
  ready_wait_a: assert property (@(posedge clk) disable iff (rst)
    $rose(ready_q) |-> ext_set_q && $past(wait_q) == WAIT_W'(1))
    else $error("ready raised without full wait");
  second_cmd_a: assert property (@(posedge clk) disable iff (rst)
    (st_q == ST_ACT_RD || st_q == ST_ACT_WR) |=> st_q != ST_ACT_RD && st_q != ST_ACT_WR)
    else $error("second command not taken");
  first_cmd_a: assert property (@(posedge clk) disable iff (rst)
    (st_q == ST_IDLE && power_down_n && !pins.chip_sel_n && pins.function_select)
    |=> st_q == ST_ACT_RD)
    else $error("read activate missed");
  self_entry_a: assert property (@(posedge clk) disable iff (rst)
    (st_q == ST_ACT_WR && !pins.chip_sel_n && !power_down_n) |=> st_q == ST_SELF_REF)
    else $error("self-refresh entry missed");
  sleep_exit_a: assert property (@(posedge clk) disable iff (rst)
    ((st_q == ST_SLEEP || st_q == ST_SELF_REF) && power_down_n) |=> st_q == ST_IDLE)
    else $error("low-power state held with pin high");
  mode_opcode_a: assert property (@(posedge clk) disable iff (rst)
    (st_q == ST_ACT_RD && !pins.chip_sel_n && pins.addr[ADDR_W-1:OPC_HI_LSB] != '0)
    |=> illegal_q)
    else $error("bad opcode not flagged");
  queue_push_a: assert property (@(posedge clk) disable iff (rst)
    push |-> (st_q == ST_ACT_RD || st_q == ST_ACT_WR))
    else $error("push outside second command");
  // select low with pin low flagged
  pd_illegal_a: assert property (@(posedge clk) disable iff (rst)
    (st_q == ST_IDLE && !power_down_n && !pins.chip_sel_n) |=> illegal_q && st_q == ST_IDLE)
    else $error("illegal power-down not flagged");
endmodule

// >>> sim/ctrl_model.sv
module ctrl_model
  import cmd_port_pkg::*;
#(
  parameter int STABLE_CYC = 20
) (
  input  wire logic clk,
  output pins_t     pins,
  output logic      power_down_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Controller side of the command port
  // ****************************************************************
  initial begin
    pins = '{1'b1, 1'b0, 2'h0, 15'h0};
    power_down_n = 1'b0;
  end

  // deselect between commands. A released bus shows the inverse value.
  task automatic desel();
    pins.chip_sel_n = 1'b1;
    pins.addr = ~pins.addr;
    pins.bank = ~pins.bank;
  endtask

  // stable clock, then deselect with pin high. The wait is shortened.
  task automatic power_up();
    repeat (STABLE_CYC) @(posedge clk);
    #1;
    desel();
    power_down_n = 1'b1;
  endtask

  // pin low inside the entry window, outputs idle.
  task automatic pair(input logic fn, input logic [1:0] ba, input logic [14:0] ua,
                      input logic cs2_n, input logic [14:0] a2, input logic [1:0] ba2,
                      input logic sr);
    @(posedge clk);
    #1;
    pins = '{1'b0, fn, ba, ua};
    @(posedge clk);
    #1;
    pins = '{cs2_n, ~fn, ba2, a2};
    @(posedge clk);
    #1;
    desel();
    if (sr) begin
      #2;
      power_down_n = 1'b0;
    end
  endtask

  // entry tried with select low, which the device must flag.
  task automatic bad_sleep();
    @(posedge clk);
    #1;
    pins.chip_sel_n = 1'b0;
    power_down_n = 1'b0;
    @(posedge clk);
    #1;
    desel();
    power_down_n = 1'b1;
  endtask

  task automatic sleep();
    @(posedge clk);
    #1;
    power_down_n = 1'b0;
  endtask

  // Exit is raised mid-cycle so no clock edge can help the design.
  task automatic wake();
    #2;
    power_down_n = 1'b1;
  endtask
endmodule

// >>> sim/ddr_fast_cycle_dram_command_port_tb.sv
module ddr_fast_cycle_dram_command_port_tb
  import cmd_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Bench
  // ****************************************************************
  localparam int WAIT = 4;
  logic       clk, rst, cmd_ready, cmd_valid, cmd_dropped_q, ready_q, ext_set_q;
  logic       sleeping, self_refreshing, illegal_q, power_down_n, seen_ill, seen_drop;
  logic [1:0] burst_length;
  pins_t      pins;
  cmd_t       cmd_data, d;
  int         miscompares, total_checks, cycles;

  cmd_port #(.WIDE_ORG(1'b1), .READY_WAIT(WAIT)) cmd_port_i (
    .clk(clk), .rst(rst), .pins(pins), .power_down_n(power_down_n),
    .burst_length(burst_length), .outputs_idle(1'b1), .cmd_data(cmd_data),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_dropped_q(cmd_dropped_q),
    .ready_q(ready_q), .ext_set_q(ext_set_q), .sleeping(sleeping),
    .self_refreshing(self_refreshing), .illegal_q(illegal_q));
  ctrl_model ctrl_model_i (.clk(clk), .pins(pins), .power_down_n(power_down_n));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (illegal_q === 1'b1) seen_ill = 1'b1;
    if (cmd_dropped_q === 1'b1) seen_drop = 1'b1;
    if (cycles == 3000) begin
      miscompares++;
      results();
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic pop(input op_t op);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (cmd_valid !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    d = cmd_data;
    check("op", 32'(op), 32'(d.op));
    cmd_ready = 1'b1;
    @(posedge clk);
    #1;
    cmd_ready = 1'b0;
  endtask

  task automatic flush();
    repeat (6) begin
      @(posedge clk);
      #1;
      cmd_ready = 1'b1;
    end
    @(posedge clk);
    #1;
    cmd_ready = 1'b0;
  endtask

  // Select code is {first select, second select}; zero means reserved on burst four.
  function automatic logic [3:0] wmask(input logic bl4, input logic [1:0] c);
    if (!bl4) return c[1] ? 4'h1 : 4'h3;
    case (c)
      2'b10:   return 4'hf;
      2'b01:   return 4'h3;
      2'b11:   return 4'h1;
      default: return 4'h0;
    endcase
  endfunction

  task automatic wr(input logic [1:0] bl, input logic [1:0] lo, input logic [1:0] hi);
    burst_length = bl;
    ctrl_model_i.pair(1'b0, 2'h1, 15'h1a5c, 1'b1, {lo, hi, 3'h7, 8'h3c}, 2'h2, 1'b0);
    pop(OP_WRITE);
    check("lane_lo", 32'(wmask(bl[0], lo)), 32'(d.word_mask_lo));
    check("lane_hi", 32'(wmask(bl[0], hi)), 32'(d.word_mask_hi));
    check("col", 32'h3c, 32'(d.lower_address));
  endtask

  task automatic results();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    cmd_ready = 1'b0;
    burst_length = BURST_LEN_4;
    {miscompares, total_checks, cycles} = '0;
    {seen_ill, seen_drop} = 2'b00;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    check("valid_rst", 32'h0, 32'(cmd_valid));
    ctrl_model_i.power_up();
    ctrl_model_i.pair(1'b1, 2'h2, 15'h0, 1'b0, 15'h0003, 2'h2, 1'b0);
    check("ready_early", 32'h0, 32'(ready_q));
    check("ext_set", 32'h1, 32'(ext_set_q));
    pop(OP_EXT);
    ctrl_model_i.pair(1'b1, 2'h0, 15'h0, 1'b0, 15'h0032, 2'h0, 1'b0);
    pop(OP_MODE);
    repeat (2) begin
      ctrl_model_i.pair(1'b0, 2'h0, 15'h0, 1'b0, 15'h0, 2'h0, 1'b0);
      pop(OP_REFR);
    end
    repeat (WAIT) @(posedge clk);
    #1;
    check("ready", 32'h1, 32'(ready_q));
    ctrl_model_i.pair(1'b1, 2'h3, 15'h4321, 1'b1, 15'h01a7, 2'h0, 1'b0);
    pop(OP_READ);
    check("bank", 32'h3, 32'(d.bank));
    check("upper", 32'h4321, 32'(d.upper_address));
    check("lower", 32'h0a7, 32'(d.lower_address));
    for (int k = 1; k < 4; k++) begin
      wr(BURST_LEN_2, 2'(k), 2'(k % 3 + 1));
      wr(BURST_LEN_4, 2'(k), 2'(k % 3 + 1));
    end
    repeat (5) ctrl_model_i.pair(1'b0, 2'h0, 15'h0, 1'b0, 15'h0, 2'h0, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    check("dropped", 32'h1, 32'(seen_drop));
    repeat (4) pop(OP_REFR);
    check("empty", 32'h0, 32'(cmd_valid));
    seen_ill = 1'b0;
    wr(BURST_LEN_4, 2'b00, 2'b10);
    check("reserved", 32'h1, 32'(seen_ill));
    flush();
    seen_ill = 1'b0;
    ctrl_model_i.pair(1'b1, 2'h0, 15'h0, 1'b0, 15'h0132, 2'h0, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    check("mode_high", 32'h1, 32'(seen_ill));
    flush();
    ctrl_model_i.pair(1'b0, 2'h0, 15'h0, 1'b0, 15'h0, 2'h0, 1'b1);
    @(posedge clk);
    #1;
    check("self_ref", 32'h1, 32'(self_refreshing));
    ctrl_model_i.wake();
    #1;
    check("self_exit", 32'h0, 32'(self_refreshing));
    flush();
    ctrl_model_i.sleep();
    @(posedge clk);
    #1;
    check("sleep", 32'h1, 32'(sleeping));
    ctrl_model_i.wake();
    #1;
    check("sleep_exit", 32'h0, 32'(sleeping));
    seen_ill = 1'b0;
    ctrl_model_i.bad_sleep();
    @(posedge clk);
    #1;
    check("pd_illegal", 32'h1, 32'(seen_ill));
    check("pd_stay", 32'h0, 32'(sleeping));
    results();
  end
endmodule
